// [hw/tlc_consts.svh]
`ifndef TLC_CONSTS_SVH
`define TLC_CONSTS_SVH
`define TLC_OFS_LINK_COMMAND   8'hC0
`define TLC_RESET_VALUE        32'h00400008
`define TLC_BIT_DROP           28
`define TLC_BIT_DIR_SEL        27
`define TLC_BIT_MASTER         26
`define TLC_IFTYPE_HI          31
`define TLC_IFTYPE_LO          29
`define TLC_UID_COUNT_HI       25
`define TLC_UID_COUNT_LO       21
`define TLC_BASE_ID_HI         20
`define TLC_BASE_ID_LO         16
`define TLC_CAP_ID_HI          7
`define TLC_CAP_ID_LO          0
`define TLC_IFTYPE_VAL         3'h0
`define TLC_UID_COUNT_VAL      5'h02
`define TLC_CAP_ID_VAL         8'h08
`define TLC_BYTE_HI2           3
`define TLC_BYTE_HI1           2
`endif

// [hw/tlc_pkg.sv]
package tlc_pkg;
  typedef enum logic {TLC_SIDE_A, TLC_SIDE_B} tlc_side_e;
  typedef logic [4:0] tlc_uid_t;
endpackage

// [hw/tlc_route.sv]
`timescale 1ns/1ps
`include "tlc_consts.svh"
// Forwarding decision for one tunnel side: hold, act as end of chain, or pass
module tlc_route
  import tlc_pkg::*;
(
  input  wire logic i_drop_uninit_policy,
  input  wire logic i_init_complete_flag,
  input  wire logic i_end_of_chain_flag,
  output logic      o_hold,
  output logic      o_as_end_of_chain
);
  logic uninit;
  always_comb begin
    uninit            = !i_init_complete_flag && !i_end_of_chain_flag;
    o_hold            = uninit && !i_drop_uninit_policy;
    o_as_end_of_chain = i_end_of_chain_flag ||
                        (uninit && i_drop_uninit_policy);
  end
endmodule // tlc_route

// [hw/tlc_link_command.sv]
`timescale 1ns/1ps
`include "tlc_consts.svh"
// Summary of operation
// - Drop policy 0: traffic to uninitialized side waits in buffers for init complete.
// - Drop policy 1: traffic to uninitialized side treated as end of chain.
// - Drop policy cleared only by power-good reset, survives warm reset.
// - Default direction 0 routes to master-host side, 1 to opposite side.
// - Side B write to any upper-half byte sets master-host flag.
// - Side A write to any upper-half byte clears master-host flag.
// - Unit identifier count field reads two.
// - Base unit identifier tags outgoing request and response packets.
// - Response to a base identifier write uses the new value.
// - Interface type and capability id read-only; bits 15:8 reserved zero.
module tlc_link_command
  import tlc_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  input  wire logic        i_power_good_reset_n,
  input  wire logic        i_cfg_wr,
  input  wire logic        i_cfg_rd,
  input  wire logic [7:0]  i_cfg_addr,
  input  wire logic [3:0]  i_cfg_be,
  input  wire logic [31:0] i_cfg_wdata,
  input  wire logic        i_cfg_from_b,
  input  wire logic        i_init_complete_flag_a,
  input  wire logic        i_end_of_chain_flag_a,
  input  wire logic        i_init_complete_flag_b,
  input  wire logic        i_end_of_chain_flag_b,
  output logic      [31:0] o_cfg_rdata,
  output logic             o_cfg_ack,
  output logic      [4:0]  o_rsp_unit_id,
  output logic      [4:0]  o_base_unit_identifier,
  output logic             o_drop_uninit_policy,
  output logic             o_default_direction_sel,
  output logic             o_master_host_side,
  output logic             o_sec_master_to_b,
  output logic             o_hold_a,
  output logic             o_hold_b,
  output logic             o_as_eoc_a,
  output logic             o_as_eoc_b
);

  // Drop policy sits in the power-good domain so a warm reset cannot reach it
  logic        drop_reg;
  logic        drop_next;
  // Fields cleared by warm reset
  logic        dir_sel_reg;
  logic        dir_sel_next;
  logic        master_reg;
  logic        master_next;
  tlc_uid_t    base_id_reg;
  tlc_uid_t    base_id_next;
  // Access answer
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        ack_reg;
  logic        ack_next;
  tlc_uid_t    rsp_uid_reg;
  tlc_uid_t    rsp_uid_next;
  // Forwarding decisions
  logic        to_b_reg;
  logic        to_b_next;
  tlc_side_e   sec_side;
  logic        hold_a_reg;
  logic        hold_a_next;
  logic        hold_b_reg;
  logic        hold_b_next;
  logic        eoc_a_reg;
  logic        eoc_a_next;
  logic        eoc_b_reg;
  logic        eoc_b_next;
  // Access decode
  logic        hit;
  logic        wr_hit;
  logic        rd_hit;
  logic        lane_hi2;
  logic        lane_hi1;
  logic        upper_touch;

  // Fixed fields are rebuilt on every read; only the four writable fields are stored
  function automatic logic [31:0] reg_image(input logic     drop,
                                            input logic     dir_sel,
                                            input logic     master_b,
                                            input tlc_uid_t base_id);
    logic [31:0] v;
    v = 32'h00000000;
    v[`TLC_IFTYPE_HI:`TLC_IFTYPE_LO]       = `TLC_IFTYPE_VAL;
    v[`TLC_BIT_DROP]                       = drop;
    v[`TLC_BIT_DIR_SEL]                    = dir_sel;
    v[`TLC_BIT_MASTER]                     = master_b;
    v[`TLC_UID_COUNT_HI:`TLC_UID_COUNT_LO] = `TLC_UID_COUNT_VAL;
    v[`TLC_BASE_ID_HI:`TLC_BASE_ID_LO]     = base_id;
    v[`TLC_CAP_ID_HI:`TLC_CAP_ID_LO]       = `TLC_CAP_ID_VAL;
    return v;
  endfunction

  function automatic logic lane_written(input logic        wr,
                                        input logic [3:0]  be,
                                        input int unsigned lane);
    return wr && be[lane];
  endfunction

  // Default direction 0 follows the master-host side, 1 goes the other way
  function automatic tlc_side_e sec_master_side(input logic dir_sel,
                                                input logic master_b);
    tlc_side_e host_side;
    host_side = master_b ? TLC_SIDE_B : TLC_SIDE_A;
    if (dir_sel) begin
      return (host_side == TLC_SIDE_B) ? TLC_SIDE_A : TLC_SIDE_B;
    end
    return host_side;
  endfunction

  always_comb begin
    hit         = (i_cfg_addr == `TLC_OFS_LINK_COMMAND);
    wr_hit      = i_cfg_wr && hit;
    rd_hit      = i_cfg_rd && hit;
    lane_hi2    = lane_written(wr_hit, i_cfg_be, `TLC_BYTE_HI2);
    lane_hi1    = lane_written(wr_hit, i_cfg_be, `TLC_BYTE_HI1);
    // Any write into the upper half records its side, whatever the data
    upper_touch = lane_hi2 || lane_hi1;
  end

  always_comb begin
    drop_next = drop_reg;
    if (lane_hi2) begin
      drop_next = i_cfg_wdata[`TLC_BIT_DROP];
    end
  end

  // Only power-good clears the drop policy; warm reset leaves it alone
  always_ff @(posedge i_mclk or negedge i_power_good_reset_n) begin
    if (!i_power_good_reset_n) begin
      drop_reg <= 1'b0;
    end else begin
      drop_reg <= drop_next;
    end
  end

  always_comb begin
    dir_sel_next = dir_sel_reg;
    master_next  = master_reg;
    base_id_next = base_id_reg;
    if (lane_hi2) begin
      dir_sel_next = i_cfg_wdata[`TLC_BIT_DIR_SEL];
    end
    if (lane_hi1) begin
      base_id_next = i_cfg_wdata[`TLC_BASE_ID_HI:`TLC_BASE_ID_LO];
    end
    if (upper_touch) begin
      master_next = i_cfg_from_b;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dir_sel_reg <= 1'b0;
      master_reg  <= 1'b0;
      base_id_reg <= 5'h00;
    end else begin
      dir_sel_reg <= dir_sel_next;
      master_reg  <= master_next;
      base_id_reg <= base_id_next;
    end
  end

  always_comb begin
    // Read data is zero off-address so a stray read never leaks state
    rdata_next   = rd_hit ? reg_image(drop_reg, dir_sel_reg, master_reg, base_id_reg)
                          : 32'h00000000;
    ack_next     = i_cfg_wr || i_cfg_rd;
    // Response tag follows the value just written, not the old one
    rsp_uid_next = base_id_next;
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_reg   <= 32'h00000000;
      ack_reg     <= 1'b0;
      rsp_uid_reg <= 5'h00;
    end else begin
      rdata_reg   <= rdata_next;
      ack_reg     <= ack_next;
      rsp_uid_reg <= rsp_uid_next;
    end
  end

  tlc_route u_route_a (
    .i_drop_uninit_policy (drop_reg),
    .i_init_complete_flag (i_init_complete_flag_a),
    .i_end_of_chain_flag  (i_end_of_chain_flag_a),
    .o_hold               (hold_a_next),
    .o_as_end_of_chain    (eoc_a_next)
  );

  tlc_route u_route_b (
    .i_drop_uninit_policy (drop_reg),
    .i_init_complete_flag (i_init_complete_flag_b),
    .i_end_of_chain_flag  (i_end_of_chain_flag_b),
    .o_hold               (hold_b_next),
    .o_as_end_of_chain    (eoc_b_next)
  );

  // Next field values are used so the route flips in the same cycle as the field
  always_comb begin
    sec_side  = sec_master_side(dir_sel_next, master_next);
    to_b_next = (sec_side == TLC_SIDE_B);
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      to_b_reg   <= 1'b0;
      hold_a_reg <= 1'b0;
      hold_b_reg <= 1'b0;
      eoc_a_reg  <= 1'b0;
      eoc_b_reg  <= 1'b0;
    end else begin
      to_b_reg   <= to_b_next;
      hold_a_reg <= hold_a_next;
      hold_b_reg <= hold_b_next;
      eoc_a_reg  <= eoc_a_next;
      eoc_b_reg  <= eoc_b_next;
    end
  end

  always_comb begin
    o_cfg_rdata             = rdata_reg;
    o_cfg_ack               = ack_reg;
    o_rsp_unit_id           = rsp_uid_reg;
    o_base_unit_identifier  = base_id_reg;
    o_drop_uninit_policy    = drop_reg;
    o_default_direction_sel = dir_sel_reg;
    o_master_host_side      = master_reg;
    o_sec_master_to_b       = to_b_reg;
    o_hold_a                = hold_a_reg;
    o_hold_b                = hold_b_reg;
    o_as_eoc_a              = eoc_a_reg;
    o_as_eoc_b              = eoc_b_reg;
  end

endmodule // tlc_link_command

// [tb/tlc_link_command_assertions.sv]
`timescale 1ns/1ps
module tlc_chk (
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  input  wire logic        i_power_good_reset_n,
  input  wire logic        i_cfg_wr,
  input  wire logic        i_cfg_rd,
  input  wire logic        i_cfg_from_b,
  input  wire logic        i_init_complete_flag_b,
  input  wire logic        i_end_of_chain_flag_b,
  input  wire logic [7:0]  i_cfg_addr,
  input  wire logic [3:0]  i_cfg_be,
  input  wire logic [31:0] i_cfg_wdata,
  input  wire logic        o_hold_b,
  input  wire logic        o_as_eoc_b,
  input  wire logic        o_drop_uninit_policy,
  input  wire logic        o_default_direction_sel,
  input  wire logic        o_master_host_side,
  input  wire logic        o_sec_master_to_b,
  input  wire logic [31:0] o_cfg_rdata,
  input  wire logic [4:0]  o_rsp_unit_id,
  input  wire logic [4:0]  o_base_unit_identifier
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n || !i_power_good_reset_n);
  logic w, r, u;
  assign w = i_cfg_wr && i_cfg_addr == 8'hC0 && |i_cfg_be[3:2];
  assign r = i_cfg_rd && i_cfg_addr == 8'hC0;
  // Write cycles left out: a write may move the drop policy under the check
  assign u = !i_cfg_wr && !i_init_complete_flag_b && !i_end_of_chain_flag_b;
  property p_hold; u && !o_drop_uninit_policy |=> o_hold_b; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_eoc; u && o_drop_uninit_policy |=> o_as_eoc_b && !o_hold_b; endproperty
  a_eoc: assert property (p_eoc) else $error("eoc");
  property p_set; w && i_cfg_from_b |=> o_master_host_side; endproperty
  a_set: assert property (p_set) else $error("set");
  property p_clr; w && !i_cfg_from_b |=> !o_master_host_side; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_cnt; r |=> o_cfg_rdata[25:21] == 5'h02; endproperty
  a_cnt: assert property (p_cnt) else $error("count");
  property p_ro; r |=> o_cfg_rdata[31:29] == 3'h0 && o_cfg_rdata[7:0] == 8'h08; endproperty
  a_ro: assert property (p_ro) else $error("read only");
  property p_rsv; r |=> o_cfg_rdata[15:8] == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved");
  property p_rsp; w && i_cfg_be[2] |=> o_rsp_unit_id == $past(i_cfg_wdata[20:16]); endproperty
  a_rsp: assert property (p_rsp) else $error("rsp id");
  property p_base; w && i_cfg_be[2] |=> o_base_unit_identifier == $past(i_cfg_wdata[20:16]);
  endproperty
  a_base: assert property (p_base) else $error("base id");
  property p_dir;
    o_sec_master_to_b == (o_default_direction_sel ? !o_master_host_side : o_master_host_side);
  endproperty
  a_dir: assert property (p_dir) else $error("direction");
endmodule // tlc_chk
bind tlc_link_command tlc_chk tlc_chk_i (
  .i_mclk                  (i_mclk),
  .i_reset_n               (i_reset_n),
  .i_power_good_reset_n    (i_power_good_reset_n),
  .i_cfg_wr                (i_cfg_wr),
  .i_cfg_rd                (i_cfg_rd),
  .i_cfg_from_b            (i_cfg_from_b),
  .i_init_complete_flag_b  (i_init_complete_flag_b),
  .i_end_of_chain_flag_b   (i_end_of_chain_flag_b),
  .i_cfg_addr              (i_cfg_addr),
  .i_cfg_be                (i_cfg_be),
  .i_cfg_wdata             (i_cfg_wdata),
  .o_hold_b                (o_hold_b),
  .o_as_eoc_b              (o_as_eoc_b),
  .o_drop_uninit_policy    (o_drop_uninit_policy),
  .o_default_direction_sel (o_default_direction_sel),
  .o_master_host_side      (o_master_host_side),
  .o_sec_master_to_b       (o_sec_master_to_b),
  .o_cfg_rdata             (o_cfg_rdata),
  .o_rsp_unit_id           (o_rsp_unit_id),
  .o_base_unit_identifier  (o_base_unit_identifier)
);

// [tb/tlc_peer.sv]
`timescale 1ns/1ps
// Flag levels move just after the clock edge, as same-clock link control logic would
module tlc_peer (
  input  wire logic       i_mclk,
  input  wire logic [3:0] i_mode,
  output logic [3:0]      o_flags = 4'h0
);
  always @(posedge i_mclk) o_flags <= i_mode;
endmodule // tlc_peer

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic i_mclk = 0, i_reset_n = 0, i_power_good_reset_n = 0, i_cfg_wr = 0, i_cfg_rd = 0;
  logic i_cfg_from_b = 0, o_cfg_ack, o_drop_uninit_policy, o_default_direction_sel;
  logic o_master_host_side, o_sec_master_to_b, o_hold_a, o_hold_b, o_as_eoc_a, o_as_eoc_b;
  logic [7:0] i_cfg_addr = 8'hC0;
  logic [3:0] i_cfg_be = 4'h0, mode = 4'h0;
  logic [31:0] i_cfg_wdata = 32'h0, o_cfg_rdata;
  logic [4:0] o_rsp_unit_id, o_base_unit_identifier;
  wire i_init_complete_flag_a, i_end_of_chain_flag_a;
  wire i_init_complete_flag_b, i_end_of_chain_flag_b;
  int fail_count = 0, samples_checked = 0, cyc = 0;
  tlc_peer tlc_peer_i (
    .i_mclk  (i_mclk),
    .i_mode  (mode),
    .o_flags ({i_init_complete_flag_a, i_end_of_chain_flag_a,
               i_init_complete_flag_b, i_end_of_chain_flag_b})
  );
  tlc_link_command tlc_link_command_i (
    .i_mclk                  (i_mclk),
    .i_reset_n               (i_reset_n),
    .i_power_good_reset_n    (i_power_good_reset_n),
    .i_cfg_wr                (i_cfg_wr),
    .i_cfg_rd                (i_cfg_rd),
    .i_cfg_addr              (i_cfg_addr),
    .i_cfg_be                (i_cfg_be),
    .i_cfg_wdata             (i_cfg_wdata),
    .i_cfg_from_b            (i_cfg_from_b),
    .i_init_complete_flag_a  (i_init_complete_flag_a),
    .i_end_of_chain_flag_a   (i_end_of_chain_flag_a),
    .i_init_complete_flag_b  (i_init_complete_flag_b),
    .i_end_of_chain_flag_b   (i_end_of_chain_flag_b),
    .o_cfg_rdata             (o_cfg_rdata),
    .o_cfg_ack               (o_cfg_ack),
    .o_rsp_unit_id           (o_rsp_unit_id),
    .o_base_unit_identifier  (o_base_unit_identifier),
    .o_drop_uninit_policy    (o_drop_uninit_policy),
    .o_default_direction_sel (o_default_direction_sel),
    .o_master_host_side      (o_master_host_side),
    .o_sec_master_to_b       (o_sec_master_to_b),
    .o_hold_a                (o_hold_a),
    .o_hold_b                (o_hold_b),
    .o_as_eoc_a              (o_as_eoc_a),
    .o_as_eoc_b              (o_as_eoc_b)
  );
  initial forever #5 i_mclk = ~i_mclk;
  task automatic chk(input logic [31:0] g, e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] b, input logic [31:0] d, input logic f);
    @(negedge i_mclk);
    {i_cfg_wr, i_cfg_rd, i_cfg_be, i_cfg_wdata, i_cfg_from_b} = {w, !w, b, d, f};
    @(negedge i_mclk);
    {i_cfg_wr, i_cfg_rd} = 2'b00;
    chk(o_cfg_ack, 1'b1);
  endtask
  task automatic rst(input logic p);
    {i_reset_n, i_power_good_reset_n} = {1'b0, !p};
    repeat (2) @(negedge i_mclk);
    {i_reset_n, i_power_good_reset_n} = 2'b11;
  endtask
  task automatic t_regs;
    acc(0, 4'h0, 32'h0, 0);
    chk(o_cfg_rdata, 32'h00400008);
    chk({o_hold_a, o_hold_b}, 2'b11);
    acc(1, 4'hF, 32'hFFFFFFFF, 1);
    chk({o_rsp_unit_id, o_sec_master_to_b}, {5'h1F, 1'b0});
    acc(1, 4'h4, 32'h00050000, 0);
    acc(1, 4'h3, 32'hFFFFFFFF, 1);
    chk({o_default_direction_sel, o_master_host_side, o_sec_master_to_b}, 3'b101);
    acc(0, 4'h0, 32'h0, 0);
    chk(o_cfg_rdata, 32'h18450008);
    i_cfg_addr = 8'hC4;
    acc(0, 4'h0, 32'h0, 0);
    chk(o_cfg_rdata, 32'h0);
    i_cfg_addr = 8'hC0;
    $display("t_regs done");
  endtask
  task automatic t_keep;
    chk({o_hold_a, o_as_eoc_a, o_hold_b, o_as_eoc_b}, 4'b0101);
    mode = 4'h8;
    repeat (3) @(negedge i_mclk);
    chk({o_hold_a, o_as_eoc_a, o_hold_b, o_as_eoc_b}, 4'b0001);
    rst(0);
    chk({o_drop_uninit_policy, o_base_unit_identifier}, 6'h20);
    acc(1, 4'h8, 32'h0, 0);
    repeat (2) @(negedge i_mclk);
    chk({o_hold_b, o_master_host_side}, 2'b10);
    acc(1, 4'h8, 32'h10000000, 0);
    chk(o_drop_uninit_policy, 1'b1);
    rst(1);
    chk(o_drop_uninit_policy, 1'b0);
    $display("t_keep done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge i_mclk);
    {i_reset_n, i_power_good_reset_n} = 2'b11;
    t_regs;
    t_keep;
    end_sim;
  end
  // Whole run is well under 200 cycles; a hang is cut off here
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      end_sim;
    end
  end
endmodule // testbench
